// ===== rtl/limlvl_regs.sv
// module: two-wire bus slave holding the mid and fast limiter level registers
//
// Contract
// - mid ceiling field in bits 3:0 resets to 0011; codes 0..A give 1.0-3.0 W.
// - ceiling code 1011 turns mid level off; codes 1100-1111 must not be written.
// - mid attack-rate field in bits 4:2 resets to 010, eight rate codes.
// - fast attack-rate field in bits 2:1 resets to 01, four rate codes.
// - fast register bit 0 resets to 0; 1 turns the fast level off.
// - mid register unused bits reset to zero; ceiling register bits 7:4 reset zero.
// - fast register bits 7:3 reset to 01001; software writes that default back.
module limlvl_regs
  import limlvl_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A // bus address, value arbitrary
) (
  input wire logic clk, // system clock, 40 MHz
  input wire logic rst_b, // synchronous reset, active low
  input wire logic scl_pin, // bus clock pin
  input wire logic sda_in, // bus data pin level
  output logic sda_out, // bus data drive value, always low
  output logic sda_oe, // bus data driven low while high
  output limlvl_cfg_t cfg // settings to the limiter
);
  logic scl_s;
  logic sda_s;
  logic scl_q_ff;
  logic sda_q_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  limlvl_state_t state_ff;
  logic [7:0] sh_ff;
  logic [3:0] cnt_ff;
  logic [7:0] ptr_ff;
  logic rw_ff;
  logic oe_ff;
  logic out_ff;
  logic wr_pulse_ff;
  logic [7:0] wr_addr_ff;
  logic [7:0] wr_data_ff;
  logic [7:0] ceil_ff;
  logic [7:0] mid_ff;
  logic [7:0] fast_ff;
  limlvl_cfg_t cfg_ff;
  logic [7:0] rd_cur;
  logic [7:0] rd_nxt;

  function automatic logic [7:0] rd_mux(input logic [7:0] a, input logic [7:0] c,
                                        input logic [7:0] m, input logic [7:0] f);
    logic [7:0] r;
    r = 8'h00;
    if (a == LIMLVL_OFS_MID_CEIL) begin
      r = c;
    end else if (a == LIMLVL_OFS_MID_PARAM) begin
      r = m;
    end else if (a == LIMLVL_OFS_FAST_PARAM) begin
      r = f;
    end
    return r;
  endfunction : rd_mux

  // read byte at the pointer and at the pointer plus one
  assign rd_cur = rd_mux(ptr_ff, ceil_ff, mid_ff, fast_ff);
  assign rd_nxt = rd_mux(ptr_ff + 8'h01, ceil_ff, mid_ff, fast_ff);

  limlvl_pin_sync u_scl_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin(scl_pin),
    .level(scl_s)
  );

  limlvl_pin_sync u_sda_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin(sda_in),
    .level(sda_s)
  );

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_q_ff;
  assign scl_fall = !scl_s && scl_q_ff;
  assign start_det = scl_s && scl_q_ff && sda_q_ff && !sda_s;
  assign stop_det = scl_s && scl_q_ff && !sda_q_ff && sda_s;

  // bus frame sequencer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      sh_ff <= 8'h00;
      cnt_ff <= 4'h0;
      ptr_ff <= 8'h00;
      rw_ff <= 1'b0;
      oe_ff <= 1'b0;
      wr_pulse_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      wr_data_ff <= 8'h00;
    end else begin
      wr_pulse_ff <= 1'b0;
      if (start_det) begin
        state_ff <= ST_DEV;
        cnt_ff <= 4'h0;
        oe_ff <= 1'b0;
      end else if (stop_det) begin
        state_ff <= ST_IDLE;
        oe_ff <= 1'b0;
      end else begin
        case (state_ff)
          ST_DEV, ST_REG, ST_WR: begin
            if (scl_rise) begin
              sh_ff <= {sh_ff[6:0], sda_s};
              cnt_ff <= cnt_ff + 4'h1;
            end else if (scl_fall && cnt_ff == LIMLVL_BITS_BYTE) begin
              oe_ff <= 1'b1;
              if (state_ff == ST_DEV) begin
                rw_ff <= sh_ff[0];
                if (sh_ff[7:1] == DEV_ADDR) begin
                  state_ff <= ST_DEV_ACK;
                end else begin
                  state_ff <= ST_IDLE;
                  oe_ff <= 1'b0;
                end
              end else if (state_ff == ST_REG) begin
                ptr_ff <= sh_ff;
                state_ff <= ST_REG_ACK;
              end else begin
                wr_pulse_ff <= 1'b1;
                wr_addr_ff <= ptr_ff;
                wr_data_ff <= sh_ff;
                state_ff <= ST_WR_ACK;
              end
            end
          end
          ST_DEV_ACK: begin
            if (scl_fall) begin
              cnt_ff <= 4'h0;
              if (rw_ff) begin
                sh_ff <= rd_cur;
                oe_ff <= !rd_cur[7];
                state_ff <= ST_RD;
              end else begin
                oe_ff <= 1'b0;
                state_ff <= ST_REG;
              end
            end
          end
          ST_REG_ACK, ST_WR_ACK: begin
            if (scl_fall) begin
              oe_ff <= 1'b0;
              cnt_ff <= 4'h0;
              state_ff <= ST_WR;
              if (state_ff == ST_WR_ACK) begin
                ptr_ff <= ptr_ff + 8'h01;
              end
            end
          end
          ST_RD: begin
            if (scl_rise) begin
              cnt_ff <= cnt_ff + 4'h1;
            end else if (scl_fall) begin
              if (cnt_ff == LIMLVL_BITS_BYTE) begin
                oe_ff <= 1'b0;
                state_ff <= ST_RD_ACK;
              end else begin
                sh_ff <= {sh_ff[6:0], 1'b0};
                oe_ff <= !sh_ff[6];
              end
            end
          end
          ST_RD_ACK: begin
            if (scl_rise && sda_s) begin
              state_ff <= ST_IDLE;
            end else if (scl_fall) begin
              ptr_ff <= ptr_ff + 8'h01;
              sh_ff <= rd_nxt;
              oe_ff <= !rd_nxt[7];
              cnt_ff <= 4'h0;
              state_ff <= ST_RD;
            end
          end
          default: begin
            state_ff <= ST_IDLE;
            oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // register storage; unavailable ceiling codes leave the register unchanged
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ceil_ff <= LIMLVL_RST_MID_CEIL;
      mid_ff <= LIMLVL_RST_MID_PARAM;
      fast_ff <= LIMLVL_RST_FAST_PARAM;
    end else if (wr_pulse_ff) begin
      if (wr_addr_ff == LIMLVL_OFS_MID_CEIL) begin
        if (wr_data_ff[3:0] <= LIMLVL_CEIL_OFF) begin
          ceil_ff <= wr_data_ff;
        end
      end else if (wr_addr_ff == LIMLVL_OFS_MID_PARAM) begin
        mid_ff <= wr_data_ff;
      end else if (wr_addr_ff == LIMLVL_OFS_FAST_PARAM) begin
        fast_ff <= wr_data_ff;
      end
    end
  end

  // settings to the limiter follow the registers one cycle later
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg_ff.mid_level_power_ceiling <= LIMLVL_RST_CEIL;
      cfg_ff.mid_level_off <= 1'b0;
      cfg_ff.mid_level_attack_rate <= LIMLVL_RST_MID_AT;
      cfg_ff.fast_level_attack_rate <= LIMLVL_RST_FAST_AT;
      cfg_ff.fast_level_disable <= 1'b0;
    end else begin
      cfg_ff.mid_level_power_ceiling <= ceil_ff[LIMLVL_CEIL_LSB +: 4];
      cfg_ff.mid_level_off <= ceil_ff[3:0] == LIMLVL_CEIL_OFF;
      cfg_ff.mid_level_attack_rate <= mid_ff[LIMLVL_MID_AT_LSB +: 3];
      cfg_ff.fast_level_attack_rate <= fast_ff[LIMLVL_FAST_AT_LSB +: 2];
      cfg_ff.fast_level_disable <= fast_ff[LIMLVL_FAST_DIS_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      out_ff <= 1'b0;
    end else begin
      out_ff <= 1'b0;
    end
  end

  assign sda_out = out_ff;
  assign sda_oe = oe_ff;
  assign cfg = cfg_ff;

  sequence s_wr_ceil;
    wr_pulse_ff && wr_addr_ff == LIMLVL_OFS_MID_CEIL;
  endsequence

  sequence s_wr_mid;
    wr_pulse_ff && wr_addr_ff == LIMLVL_OFS_MID_PARAM;
  endsequence

  sequence s_wr_fast;
    wr_pulse_ff && wr_addr_ff == LIMLVL_OFS_FAST_PARAM;
  endsequence

  a_ceil_reset: assert property (@(posedge clk) !rst_b |=> ceil_ff == 8'h03 ##1
    cfg_ff.mid_level_power_ceiling == 4'h3 || !rst_b)
    else $error("ceiling register reset wrong");
  a_ceil_off: assert property (@(posedge clk) disable iff (!rst_b)
    s_wr_ceil ##0 wr_data_ff[3:0] == 4'hB |=> ##1 cfg_ff.mid_level_off)
    else $error("off code did not switch mid level off");
  a_bad_code_kept: assert property (@(posedge clk) disable iff (!rst_b)
    s_wr_ceil ##0 wr_data_ff[3:0] > 4'hB |=> $stable(ceil_ff))
    else $error("unavailable ceiling code was stored");
  a_mid_reset: assert property (@(posedge clk) !rst_b |=> mid_ff[4:2] == 3'h2)
    else $error("mid attack rate reset wrong");
  a_fast_reset: assert property (@(posedge clk) !rst_b |=> fast_ff[2:1] == 2'h1)
    else $error("fast attack rate reset wrong");
  a_fast_disable: assert property (@(posedge clk) disable iff (!rst_b)
    s_wr_fast |=> ##1 cfg_ff.fast_level_disable == $past(wr_data_ff[0], 2))
    else $error("fast disable bit not applied");
  a_unused_reset: assert property (@(posedge clk) !rst_b |=>
    mid_ff[7:5] == 3'h0 && mid_ff[1:0] == 2'h0 && ceil_ff[7:4] == 4'h0)
    else $error("unused bits reset wrong");
  a_fast_unused: assert property (@(posedge clk) !rst_b |=> fast_ff[7:3] == 5'h09)
    else $error("fast register unused bits reset wrong");
  a_mid_apply: assert property (@(posedge clk) disable iff (!rst_b)
    s_wr_mid |=> ##1 cfg_ff.mid_level_attack_rate == $past(wr_data_ff[4:2], 2))
    else $error("mid attack rate not applied in two cycles");
endmodule : limlvl_regs

// ===== rtl/limlvl_pkg.sv
// package: limiter level configuration register map, defaults and types
package limlvl_pkg;

  // register offsets on the two-wire control bus
  localparam logic [7:0] LIMLVL_OFS_MID_CEIL = 8'h08;
  localparam logic [7:0] LIMLVL_OFS_MID_PARAM = 8'h09;
  localparam logic [7:0] LIMLVL_OFS_FAST_PARAM = 8'h0A;

  // reset values of whole registers
  localparam logic [7:0] LIMLVL_RST_MID_CEIL = 8'h03;
  localparam logic [7:0] LIMLVL_RST_MID_PARAM = 8'h08;
  localparam logic [7:0] LIMLVL_RST_FAST_PARAM = 8'h4A;

  // field positions and field reset values
  localparam int LIMLVL_CEIL_LSB = 0;
  localparam int LIMLVL_MID_AT_LSB = 2;
  localparam int LIMLVL_FAST_AT_LSB = 1;
  localparam int LIMLVL_FAST_DIS_BIT = 0;
  localparam logic [3:0] LIMLVL_RST_CEIL = 4'h3;
  localparam logic [2:0] LIMLVL_RST_MID_AT = 3'h2;
  localparam logic [1:0] LIMLVL_RST_FAST_AT = 2'h1;
  localparam logic [4:0] LIMLVL_RST_FAST_UNUSED = 5'h09;

  // ceiling codes: 0..A are power steps, B switches the mid level off
  localparam logic [3:0] LIMLVL_CEIL_OFF = 4'hB;

  // frame bit counts
  localparam logic [3:0] LIMLVL_BITS_BYTE = 4'h8;

  typedef struct packed {
    logic [3:0] mid_level_power_ceiling;
    logic mid_level_off;
    logic [2:0] mid_level_attack_rate;
    logic [1:0] fast_level_attack_rate;
    logic fast_level_disable;
  } limlvl_cfg_t;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_DEV = 9'h002,
    ST_DEV_ACK = 9'h004,
    ST_REG = 9'h008,
    ST_REG_ACK = 9'h010,
    ST_WR = 9'h020,
    ST_WR_ACK = 9'h040,
    ST_RD = 9'h080,
    ST_RD_ACK = 9'h100
  } limlvl_state_t;

endpackage : limlvl_pkg

// ===== rtl/limlvl_pin_sync.sv
// module: three-stage pin synchroniser, level taken once stages two and three agree
module limlvl_pin_sync (
  input wire logic clk, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic pin, // asynchronous pin level
  output logic level // filtered level
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      level_ff <= 1'b1;
    end else if (s2_ff == s3_ff) begin
      level_ff <= s3_ff;
    end
  end

  assign level = level_ff;
endmodule : limlvl_pin_sync

// ===== verif/tb.sv
// testbench: limiter level registers exercised over the two-wire bus
module tb
  import limlvl_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] ADDR = 7'h2A; // arbitrary bus address
  localparam int HALF = 12;
  localparam int LIMIT = 60000;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic scl = 1'b1;
  logic m_sda = 1'b1;
  logic sda_out;
  logic sda_oe;
  logic sda_w;
  limlvl_cfg_t cfg;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [7:0] sh [3];
  logic [7:0] q0;
  logic [7:0] q1;
  logic ak;

  // open-drain data wire: low if either side pulls
  assign sda_w = m_sda & ~sda_oe;

  always #12.5 clk = ~clk;

  limlvl_regs #(.DEV_ADDR(ADDR)) dut (
    .clk(clk),
    .rst_b(rst_b),
    .scl_pin(scl),
    .sda_in(sda_w),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .cfg(cfg)
  );

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic hc(input int n);
    repeat (n) @(negedge clk);
  endtask : hc

  // data moves only while the bus clock is low
  task automatic bitx(input logic b, output logic r);
    hc(4);
    m_sda = b;
    hc(HALF);
    scl = 1'b1;
    hc(HALF);
    r = sda_w;
    scl = 1'b0;
  endtask : bitx

  task automatic start;
    hc(4);
    m_sda = 1'b1;
    hc(HALF);
    scl = 1'b1;
    hc(HALF);
    m_sda = 1'b0;
    hc(HALF);
    scl = 1'b0;
  endtask : start

  task automatic stop;
    hc(4);
    m_sda = 1'b0;
    hc(HALF);
    scl = 1'b1;
    hc(HALF);
    m_sda = 1'b1;
    hc(HALF);
  endtask : stop

  task automatic xb(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                    output logic a);
    for (int i = 7; i >= 0; i--) begin
      bitx(tx[i], rx[i]);
    end
    bitx(mack, a);
  endtask : xb

  task automatic wr(input logic [7:0] r, input logic [7:0] d0, input logic [7:0] d1,
                    input int n);
    logic [7:0] x;
    logic a;
    start();
    xb({ADDR, 1'b0}, 1'b1, x, a);
    chk(16'(a), 16'h0000);
    xb(r, 1'b1, x, a);
    chk(16'(a), 16'h0000);
    xb(d0, 1'b1, x, a);
    chk(16'(a), 16'h0000);
    if (n > 1) begin
      xb(d1, 1'b1, x, a);
      chk(16'(a), 16'h0000);
    end
    stop();
    hc(4);
  endtask : wr

  task automatic rd(input logic [7:0] r, input int n);
    logic [7:0] x;
    logic a;
    start();
    xb({ADDR, 1'b0}, 1'b1, x, a);
    xb(r, 1'b1, x, a);
    start();
    xb({ADDR, 1'b1}, 1'b1, x, a);
    xb(8'hFF, (n > 1) ? 1'b0 : 1'b1, q0, a);
    if (n > 1) begin
      xb(8'hFF, 1'b1, q1, a);
    end
    stop();
  endtask : rd

  function automatic logic [15:0] ecfg();
    limlvl_cfg_t e;
    e.mid_level_power_ceiling = sh[0][3:0];
    e.mid_level_off = (sh[0][3:0] == LIMLVL_CEIL_OFF);
    e.mid_level_attack_rate = sh[1][4:2];
    e.fast_level_attack_rate = sh[2][2:1];
    e.fast_level_disable = sh[2][0];
    return 16'(e);
  endfunction : ecfg

  initial begin
    hc(8);
    rst_b = 1'b1;
    hc(8);
    sh = '{8'h03, 8'h08, 8'h4A};
    rd(8'h08, 2);
    chk(16'(q0), 16'h0003);
    chk(16'(q1), 16'h0008);
    rd(8'h0A, 1);
    chk(16'(q0), 16'h004A);
    chk(16'(cfg), ecfg());
    $display("test reset values done");
    for (int i = 0; i < 12; i++) begin
      sh[0] = 8'(i);
      wr(8'h08, sh[0], 8'h00, 1);
      chk(16'(cfg), ecfg());
    end
    for (int i = 12; i < 16; i++) begin
      wr(8'h08, 8'(i), 8'h00, 1);
      chk(16'(cfg), ecfg());
    end
    rd(8'h08, 1);
    chk(16'(q0), 16'h000B);
    $display("test ceiling codes done");
    for (int i = 0; i < 8; i++) begin
      sh[1] = {3'h0, 3'(i), 2'h0};
      sh[2] = {5'h09, 3'(i)};
      wr(8'h09, sh[1], sh[2], 2);
      chk(16'(cfg), ecfg());
    end
    rd(8'h09, 2);
    chk(16'(q0), 16'(sh[1]));
    chk(16'(q1), 16'(sh[2]));
    $display("test rate codes done");
    rd(8'h20, 1);
    chk(16'(q0), 16'h0000);
    start();
    xb({ADDR ^ 7'h01, 1'b0}, 1'b1, q1, ak);
    chk(16'(ak), 16'h0001);
    stop();
    chk(16'(sda_out), 16'h0000);
    $display("test foreign accesses done");
    end_of_test();
  end
endmodule : tb
